// ### hw/charge_timing_edge_control.sv
/*
  Edge-control logic of the charge-timing unit: the control register,
  second-edge source selection, polarity and sampling mode, and the
  enable, idle-stop, edge-blocking and delay-generation controls.
  Assumes one 125 MHz clock, a single-cycle register port and an idle
  indication from the power controller on the same clock.
*/
// Overview of operation
// RULE1: Polarity bit clear responds to falling transitions of the source.
// RULE2: Polarity bit set responds to rising transitions of the source.
// RULE3: Bits 21..18 hold a four-bit second-edge source selector.
// RULE4: Codes 1111, 1110, 1101 pick capture 4, comparator 2, comparator 1.
// RULE5: Code 1100 routes the bus clock itself as the source; the code routes a register toggling every cycle instead.
// RULE6: Codes 1011, 1010, 1001 pick capture units 3, 2 and 1.
// RULE7: Codes 1000..0100 pick pins 13..9; 0011 pin 1; 0010 pin 2.
// RULE8: Code 0001 picks compare unit 1; code 0000 picks timer 1.
// RULE9: Bits 17, 16 and 14 read zero and ignore writes.
// RULE10: Bit 15 enables the unit; clear disables it.
// RULE11: Bit 13 set stops the unit while the device is idle.
// RULE12: Bit 12 enables edge delay generation.
// RULE13: Bit 11 clear blocks all edges; set lets them pass.
// RULE14: Software selects comparator 2 whenever delay generation is on.
// RULE15: Software discharges the sample capacitor via the ground bit.
// RULE16: Software keeps the converter sampling while grounding is active.
// RULE17: Second-edge status sets on a qualifying edge; software may write it.
// RULE18: With ordering on, a second edge needs a prior first edge.
// RULE19: Sampling-mode bit set means edge-sensitive, clear level-sensitive.
// RULE20: Disabled or blocked unit leaves status alone; writes still act.
// RULE21: Edge sources are resynchronised to the bus clock first.
`timescale 1ns/1ns
`default_nettype none
module charge_timing_edge_control (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Register port
  input wire logic [charge_timing_pkg::ADDR_W-1:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  // Power state, same clock
  input wire logic idle_in,
  // First-edge event from the first-edge logic, same clock
  input wire logic first_edge_in,
  // Second-edge sources, asynchronous
  input wire logic capture_unit_4_event_in,
  input wire logic comparator_2_output_in,
  input wire logic comparator_1_output_in,
  input wire logic capture_unit_3_event_in,
  input wire logic capture_unit_2_event_in,
  input wire logic capture_unit_1_event_in,
  input wire logic edge_pin_13_in,
  input wire logic edge_pin_12_in,
  input wire logic edge_pin_11_in,
  input wire logic edge_pin_10_in,
  input wire logic edge_pin_9_in,
  input wire logic edge_pin_1_in,
  input wire logic edge_pin_2_in,
  input wire logic compare_unit_1_event_in,
  input wire logic first_timer_event_in,
  // Controls to the analog section
  output logic active_out,
  output logic delay_generation_out,
  output logic current_source_ground_out,
  output logic trigger_enable_out,
  output logic second_edge_status_out,
  output logic first_edge_status_out
);

  logic [31:0] ctl_r;
  logic [31:0] rdata_r;
  logic [15:0] meta_r;
  logic [15:0] sync_r;
  logic clk_image_r;
  logic prev_r;
  logic active_r;
  logic [15:0] raw;
  logic [15:0] sources;
  logic chosen;
  logic [3:0] second_edge_source_select;
  logic second_edge_polarity;
  logic second_edge_sampling_mode;
  logic edge_order_enforce;
  logic running;
  logic qualifies;
  logic order_ok;
  logic second_hit;
  logic first_hit;
  logic ctl_wr;

  assign second_edge_source_select =
    ctl_r[charge_timing_pkg::SECOND_SELECT_MSB:
          charge_timing_pkg::SECOND_SELECT_LSB];
  assign second_edge_polarity = ctl_r[charge_timing_pkg::SECOND_POLARITY_BIT];
  assign second_edge_sampling_mode = ctl_r[charge_timing_pkg::SECOND_MODE_BIT];
  assign edge_order_enforce = ctl_r[charge_timing_pkg::EDGE_ORDER_BIT];
  assign ctl_wr = wr_in && charge_timing_pkg::control_hit(addr_in);

  // Raw inputs in select-code order; slot 12 is unused here because the
  // bus clock has no pin and is replaced after synchronisation.
  assign raw = {capture_unit_4_event_in, comparator_2_output_in, // see RULE4
                comparator_1_output_in, 1'b0,
                capture_unit_3_event_in, capture_unit_2_event_in, // see RULE6
                capture_unit_1_event_in,
                edge_pin_13_in, edge_pin_12_in, edge_pin_11_in, // see RULE7
                edge_pin_10_in, edge_pin_9_in,
                edge_pin_1_in, edge_pin_2_in,
                compare_unit_1_event_in, first_timer_event_in}; // see RULE8

  // Two-stage synchroniser; only sync_r is looked at by logic.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_r <= 16'h0000;
      sync_r <= 16'h0000;
    end else begin
      meta_r <= raw; // see RULE21
      sync_r <= meta_r; // see RULE21
    end
  end

  // The bus clock cannot be sampled by itself, so it is stood in for by
  // a register toggling every cycle: one rising and one falling edge per
  // two clock periods, the fastest pattern the detector can resolve.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      clk_image_r <= 1'b0;
    end else begin
      clk_image_r <= ~clk_image_r;
    end
  end

  assign sources = {sync_r[15:13], clk_image_r, sync_r[11:0]}; // see RULE5

  edge_source_mux #(
    .N(16)
  ) u_mux (
    .source_in(sources),
    .select_in(second_edge_source_select), // see RULE3
    .chosen_out(chosen)
  );

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= chosen;
    end
  end

  // Unit runs when enabled, edges pass, and it is not stopped by idle.
  assign running = ctl_r[charge_timing_pkg::MODULE_ENABLE_BIT] && // see RULE10
    ctl_r[charge_timing_pkg::EDGE_PASS_BIT] && // see RULE13
    !(ctl_r[charge_timing_pkg::STOP_WHEN_IDLE_BIT] && idle_in); // see RULE11

  always_comb begin
    if (second_edge_sampling_mode) begin // see RULE19
      qualifies = second_edge_polarity ? (chosen && !prev_r) // see RULE2
                                       : (!chosen && prev_r); // see RULE1
    end else begin
      qualifies = second_edge_polarity ? chosen : !chosen;
    end
  end

  assign order_ok = !edge_order_enforce || // see RULE18
    ctl_r[charge_timing_pkg::FIRST_STATUS_BIT];
  assign second_hit = running && qualifies && order_ok; // see RULE20
  assign first_hit = running && first_edge_in;

  // Control register.  A hardware set wins over a software clear that
  // lands in the same cycle, so no edge is lost.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ctl_r <= charge_timing_pkg::CONTROL_RESET;
    end else begin
      if (ctl_wr) begin
        ctl_r <= wdata_in & charge_timing_pkg::CONTROL_WRITE_MASK; // see RULE9
      end
      ctl_r[charge_timing_pkg::SECOND_STATUS_BIT] <= second_hit || // see RULE17
        (ctl_wr ? wdata_in[charge_timing_pkg::SECOND_STATUS_BIT]
                : ctl_r[charge_timing_pkg::SECOND_STATUS_BIT]);
      ctl_r[charge_timing_pkg::FIRST_STATUS_BIT] <= first_hit ||
        (ctl_wr ? wdata_in[charge_timing_pkg::FIRST_STATUS_BIT]
                : ctl_r[charge_timing_pkg::FIRST_STATUS_BIT]);
    end
  end

  // Read data stand for one cycle only; unmapped addresses read zero.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_r <= 32'h0000_0000;
    end else if (rd_in && charge_timing_pkg::control_hit(addr_in)) begin
      rdata_r <= ctl_r;
    end else begin
      rdata_r <= 32'h0000_0000;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      active_r <= 1'b0;
    end else begin
      active_r <= ctl_r[charge_timing_pkg::MODULE_ENABLE_BIT] && // see RULE10
        !(ctl_r[charge_timing_pkg::STOP_WHEN_IDLE_BIT] && idle_in); // see RULE11
    end
  end

  assign rdata_out = rdata_r;
  assign active_out = active_r;
  // Delay generation expects comparator 2 as source; software sets that.
  assign delay_generation_out = ctl_r[charge_timing_pkg::DELAY_GEN_BIT]; // see RULE12
  assign current_source_ground_out = // see RULE15
    ctl_r[charge_timing_pkg::CURRENT_GROUND_BIT];
  assign trigger_enable_out = ctl_r[charge_timing_pkg::TRIGGER_ENABLE_BIT];
  assign second_edge_status_out = ctl_r[charge_timing_pkg::SECOND_STATUS_BIT];
  assign first_edge_status_out = ctl_r[charge_timing_pkg::FIRST_STATUS_BIT];

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);

  a_reserved_bits_zero: assert property ( // see RULE9
    rd_in |=> (rdata_out[17:16] == 2'b00 && rdata_out[14] == 1'b0))
    else $error("Unimplemented control bits read nonzero.");

  a_select_readback: assert property ( // see RULE3
    (rd_in && addr_in == charge_timing_pkg::CONTROL_OFFSET && !wr_in)
      |=> rdata_out[21:18] == $past(second_edge_source_select))
    else $error("Source selector did not read back.");

  a_rising_sets: assert property ( // see RULE2
    (running && second_edge_sampling_mode && second_edge_polarity &&
     chosen && !prev_r && order_ok) |=> second_edge_status_out)
    else $error("Rising edge did not set second-edge status.");

  a_falling_sets: assert property ( // see RULE1
    (running && second_edge_sampling_mode && !second_edge_polarity &&
     !chosen && prev_r && order_ok) |=> second_edge_status_out)
    else $error("Falling edge did not set second-edge status.");

  a_level_mode_sets: assert property ( // see RULE19
    (running && !second_edge_sampling_mode && second_edge_polarity &&
     chosen && order_ok) |=> second_edge_status_out)
    else $error("Active level did not set second-edge status.");

  a_blocked_holds: assert property ( // see RULE20
    (!ctl_r[charge_timing_pkg::EDGE_PASS_BIT] && !ctl_wr)
      |=> $stable(second_edge_status_out))
    else $error("Blocked edges changed second-edge status.");

  a_order_gates: assert property ( // see RULE18
    (edge_order_enforce && !first_edge_status_out && !ctl_wr &&
     !second_edge_status_out) |=> !second_edge_status_out)
    else $error("Second edge accepted before first edge.");

  a_clock_source: assert property ( // see RULE5
    (second_edge_source_select == charge_timing_pkg::SEL_BUS_CLOCK)
      |-> chosen == clk_image_r)
    else $error("Clock code did not route the clock image.");

  a_comparator_map: assert property ( // see RULE4
    (second_edge_source_select == charge_timing_pkg::SEL_COMPARATOR_2)
      |-> chosen == sync_r[14])
    else $error("Comparator 2 code routed the wrong source.");

  a_pin_map: assert property ( // see RULE7
    (second_edge_source_select == charge_timing_pkg::SEL_PIN_1)
      |-> chosen == sync_r[3])
    else $error("Pin 1 code routed the wrong source.");

  a_idle_stop: assert property ( // see RULE11
    (ctl_r[charge_timing_pkg::STOP_WHEN_IDLE_BIT] && idle_in)
      |=> !active_out)
    else $error("Unit kept running in idle with stop set.");

  a_enable_follow: assert property ( // see RULE10
    (!ctl_r[charge_timing_pkg::MODULE_ENABLE_BIT]) |=> !active_out)
    else $error("Unit active while disabled.");

  a_write_masks: assert property ( // see RULE9
    ctl_wr |=>
      (ctl_r & ~charge_timing_pkg::CONTROL_WRITE_MASK) == 32'h0000_0000)
    else $error("Unimplemented control bits took a write.");

  a_delay_follow: assert property ( // see RULE12
    ctl_wr |=> delay_generation_out ==
      $past(wdata_in[charge_timing_pkg::DELAY_GEN_BIT]))
    else $error("Delay generation did not follow its bit.");

  a_set_beats_clear: assert property ( // see RULE17
    (second_hit && ctl_wr) |=> second_edge_status_out)
    else $error("Software clear beat a second-edge set.");

  a_first_blocked: assert property ( // see RULE20
    (!running && !ctl_wr && !first_edge_status_out)
      |=> !first_edge_status_out)
    else $error("Stopped unit changed first-edge status.");

  a_capture_map: assert property ( // see RULE6
    (second_edge_source_select == charge_timing_pkg::SEL_CAPTURE_3 &&
     !$past(rst_in, 2)) |-> chosen == $past(capture_unit_3_event_in, 2))
    else $error("Capture 3 code routed the wrong source.");

  a_timer_map: assert property ( // see RULE8
    (second_edge_source_select == charge_timing_pkg::SEL_TIMER_1 &&
     !$past(rst_in, 2)) |-> chosen == $past(first_timer_event_in, 2))
    else $error("Timer code routed the wrong source.");

endmodule
`default_nettype wire

// ### hw/charge_timing_pkg.sv
/*
  Constants shared by the charge-timing edge-control block: the register
  offset, field positions, reset value and writable-bit mask.
  Assumes a byte-addressed register port with one aligned 32-bit word.
*/
package charge_timing_pkg;

  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CONTROL_OFFSET = 8'h00;

  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  // Bits 17, 16 and 14 do not exist and always read as zero.
  localparam logic [31:0] CONTROL_WRITE_MASK = 32'hFFFC_BFFF;

  localparam int FIRST_STATUS_BIT = 24;
  localparam int SECOND_STATUS_BIT = 25;
  localparam int SECOND_MODE_BIT = 23;
  localparam int SECOND_POLARITY_BIT = 22;
  localparam int SECOND_SELECT_MSB = 21;
  localparam int SECOND_SELECT_LSB = 18;
  localparam int MODULE_ENABLE_BIT = 15;
  localparam int STOP_WHEN_IDLE_BIT = 13;
  localparam int DELAY_GEN_BIT = 12;
  localparam int EDGE_PASS_BIT = 11;
  localparam int EDGE_ORDER_BIT = 10;
  localparam int CURRENT_GROUND_BIT = 9;
  localparam int TRIGGER_ENABLE_BIT = 8;

  // Source select codes.
  localparam logic [3:0] SEL_CAPTURE_4 = 4'hF;
  localparam logic [3:0] SEL_COMPARATOR_2 = 4'hE;
  localparam logic [3:0] SEL_COMPARATOR_1 = 4'hD;
  localparam logic [3:0] SEL_BUS_CLOCK = 4'hC;
  localparam logic [3:0] SEL_CAPTURE_3 = 4'hB;
  localparam logic [3:0] SEL_CAPTURE_2 = 4'hA;
  localparam logic [3:0] SEL_CAPTURE_1 = 4'h9;
  localparam logic [3:0] SEL_PIN_13 = 4'h8;
  localparam logic [3:0] SEL_PIN_9 = 4'h4;
  localparam logic [3:0] SEL_PIN_1 = 4'h3;
  localparam logic [3:0] SEL_PIN_2 = 4'h2;
  localparam logic [3:0] SEL_COMPARE_1 = 4'h1;
  localparam logic [3:0] SEL_TIMER_1 = 4'h0;

  function automatic logic control_hit(input logic [ADDR_W-1:0] addr);
    return addr == CONTROL_OFFSET;
  endfunction

endpackage

// ### hw/edge_source_mux.sv
/*
  Sixteen-to-one selector for the second-edge source.
  Assumes every input is already in the bus clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
module edge_source_mux #(
  parameter int N = 16
) (
  // Candidate sources, indexed by select code
  input wire logic [N-1:0] source_in,
  input wire logic [$clog2(N)-1:0] select_in,
  // Chosen source
  output logic chosen_out
);

  assign chosen_out = source_in[select_in];

endmodule
`default_nettype wire

// ### verification/edge_source_model.sv
/*
  Behavioural model of the on-chip event sources that feed the second-edge
  selector: one level per select code, index 12 unused.
  Assumes the bench calls set_vec and shares the bus clock with it.
*/
`timescale 1ns/1ns
`default_nettype none
module edge_source_model (
  // Clock
  input wire logic clk_in,
  // Source levels, indexed by select code
  output logic [15:0] lvl_out
);
  initial lvl_out = 16'h0000;

  // A lag of several cycles mimics a slow timer or comparator response.
  task automatic set_vec(input logic [15:0] v, input int lag);
    repeat (lag + 1) @(posedge clk_in);
    lvl_out <= v;
  endtask
endmodule
`default_nettype wire

// ### verification/test_charge_timing_edge_control.sv
/*
  Self-checking bench for the charge-timing edge control: a register mirror
  predicts every read and every control output.
  Assumes the single-cycle register port and the two-flop source sync.
*/
`timescale 1ns/1ns
`default_nettype none
module test_charge_timing_edge_control;
  localparam logic [31:0] MASK = 32'hFFFC_BFFF;
  logic mclk_in, rst_in, wr_in, rd_in, idle_in, first_edge_in;
  logic [charge_timing_pkg::ADDR_W-1:0] addr_in;
  logic [31:0] wdata_in, rdata_out, ctl_m;
  logic act_o, dly_o, gnd_o, trg_o, st2_o, st1_o;
  logic [15:0] lvl;
  int n_fail, cmp_count;

  edge_source_model src (.clk_in(mclk_in), .lvl_out(lvl));
  charge_timing_edge_control dut (
    .mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .idle_in(idle_in),
    .first_edge_in(first_edge_in),
    .capture_unit_4_event_in(lvl[15]),
    .comparator_2_output_in(lvl[14]), .comparator_1_output_in(lvl[13]),
    .capture_unit_3_event_in(lvl[11]),
    .capture_unit_2_event_in(lvl[10]), .capture_unit_1_event_in(lvl[9]),
    .edge_pin_13_in(lvl[8]), .edge_pin_12_in(lvl[7]),
    .edge_pin_11_in(lvl[6]), .edge_pin_10_in(lvl[5]),
    .edge_pin_9_in(lvl[4]), .edge_pin_1_in(lvl[3]), .edge_pin_2_in(lvl[2]),
    .compare_unit_1_event_in(lvl[1]),
    .first_timer_event_in(lvl[0]),
    .active_out(act_o), .delay_generation_out(dly_o),
    .current_source_ground_out(gnd_o), .trigger_enable_out(trg_o),
    .second_edge_status_out(st2_o), .first_edge_status_out(st1_o));

  initial begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end

  task automatic check(input string name, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge mclk_in);
    wr_in <= 1'b0;
    if (a == 8'h00) ctl_m = d & MASK;
  endtask

  task automatic rd_cmp(input logic [7:0] a);
    logic [31:0] d;
    @(posedge mclk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
    check("rdata", d, (a == 8'h00) ? ctl_m : 32'h0000_0000);
    check("outputs", {26'h0, act_o, dly_o, gnd_o, trg_o, st2_o, st1_o},
      {26'h0, ctl_m[15] & ~(ctl_m[13] & idle_in), ctl_m[12], ctl_m[9],
      ctl_m[8], ctl_m[25], ctl_m[24]});
  endtask

  // Sync plus detect takes at most four cycles, so six leaves margin.
  task automatic drive(input logic [15:0] v, input logic hit, input int lag);
    src.set_vec(v, lag);
    repeat (6) @(posedge mclk_in);
    if (hit) ctl_m[25] = 1'b1;
    rd_cmp(8'h00);
  endtask

  initial begin
    rst_in = 1'b1;
    wr_in = 1'b0;
    rd_in = 1'b0;
    addr_in = 8'h00;
    wdata_in = 32'h0000_0000;
    idle_in = 1'b0;
    first_edge_in = 1'b0;
    ctl_m = 32'h0000_0000;
    n_fail = 0;
    cmp_count = 0;
    void'($urandom(32'h3728));
    repeat (10) @(posedge mclk_in);
    rst_in <= 1'b0;
    rd_cmp(8'h00);
    rd_cmp(8'h04);
    wr(8'h04, 32'hFFFF_FFFF);
    rd_cmp(8'h00);
    // Module kept off so the toggling bus-clock source cannot set status.
    for (int i = 0; i < 8; i++) begin
      wr(8'h00, (i == 0) ? 32'hFFFF_7FFF : ($urandom & 32'hFFFF_7FFF));
      rd_cmp(8'h00);
    end
    for (int c = 0; c < 16; c++) begin
      wr(8'h00, 32'h00C0_8800 | (32'(c) << 18));
      drive(~(16'h0001 << c), c == 12, 0);
      drive(16'hFFFF, 1'b1, c % 3);
      src.set_vec(16'h0000, 0);
      repeat (6) @(posedge mclk_in);
      // The toggling clock source may set status in the cycle of the next
      // write, and a set beats a clear, so the unit is switched off first.
      if (c == 12) wr(8'h00, 32'h0000_0000);
    end
    wr(8'h00, 32'h0080_8800);
    drive(16'h0001, 1'b0, 0);
    drive(16'h0000, 1'b1, 0);
    for (int g = 0; g < 4; g++) begin
      @(posedge mclk_in);
      idle_in <= (g >= 2);
      wr(8'h00, (g == 0) ? 32'h00C0_0800 : (g == 1) ? 32'h00C0_8000 :
        (g == 2) ? 32'h00C0_A800 : 32'h00C0_8800);
      drive(16'h0001, g == 3, 0);
      drive(16'h0000, g == 3, 0);
    end
    @(posedge mclk_in);
    idle_in <= 1'b0;
    wr(8'h00, 32'h00C0_8C00);
    drive(16'h0001, 1'b0, 0);
    drive(16'h0000, 1'b0, 0);
    @(posedge mclk_in);
    first_edge_in <= 1'b1;
    @(posedge mclk_in);
    first_edge_in <= 1'b0;
    ctl_m[24] = 1'b1;
    drive(16'h0001, 1'b1, 0);
    drive(16'h0000, 1'b1, 0);
    // Delay generation on with comparator 2 selected and ground set.
    wr(8'h00, 32'h0078_9A00);
    drive(16'h0000, 1'b0, 0);
    drive(16'h4000, 1'b1, 0);
    // Software clears status while the level still qualifies: set wins.
    wr(8'h00, 32'h0078_9A00);
    ctl_m[25] = 1'b1;
    rd_cmp(8'h00);
    finish_test;
  end

  initial begin
    repeat (20000) @(posedge mclk_in);
    n_fail++;
    finish_test;
  end
endmodule
`default_nettype wire
